/* File: hdl/mass_code_decode.sv */
// Decodes a function-select code into operation and target set mask.
// Assumes a combinational consumer.
`include "mass_map.svh"
module mass_code_decode
  import mass_pkg::*;
(
  input  wire logic [7:0]  fnCode,
  output mass_op_type      fnOp,
  output logic [3:0]       fnSets,
  output logic             fnRun,
  output logic             fnValid
);
  function automatic logic [3:0] setMask(input logic [7:0] c, input logic [7:0] lo);
    logic [7:0] d;
    d = c - lo;
    setMask = 4'h1 << d[1:0];
  endfunction

  always_comb begin
    fnOp    = MASS_OP_FULL;
    fnSets  = `MASS_SET_ALL;
    fnRun   = 1'b0;
    fnValid = 1'b1;
    if (fnCode == `MASS_FN_FULL_ALL) begin
      fnRun = 1'b1; // [RULE4]
    end else if (fnCode >= `MASS_FN_FULL_LO && fnCode <= `MASS_FN_FULL_HI) begin
      fnRun  = 1'b1;
      fnSets = setMask(fnCode, `MASS_FN_FULL_LO); // [RULE5]
    end else if (fnCode == `MASS_FN_CHECK_ALL) begin
      fnRun = 1'b1;
      fnOp  = MASS_OP_CHECK; // [RULE6]
    end else if (fnCode >= `MASS_FN_CHECK_LO && fnCode <= `MASS_FN_CHECK_HI) begin
      fnRun  = 1'b1;
      fnOp   = MASS_OP_CHECK;
      fnSets = setMask(fnCode, `MASS_FN_CHECK_LO); // [RULE7]
    end else if (fnCode == `MASS_FN_IDENT_ALL) begin
      fnRun = 1'b1;
      fnOp  = MASS_OP_IDENT; // [RULE8]
    end else if (fnCode >= `MASS_FN_IDENT_LO && fnCode <= `MASS_FN_IDENT_HI) begin
      fnRun  = 1'b1;
      fnOp   = MASS_OP_IDENT;
      fnSets = setMask(fnCode, `MASS_FN_IDENT_LO); // [RULE9]
    end else if (fnCode != `MASS_FN_CLEAR && fnCode != `MASS_FN_CONTINUE &&
                 fnCode != `MASS_FN_ABORT) begin
      fnValid = 1'b0; // [RULE21]
    end
  end
endmodule

/* File: hdl/mass_map.svh */
// Constants for the auto set-up sequencer: function codes, status codes, timings.
// Assumes inclusion by bare name from the design files.
`ifndef MASS_MAP_SVH
`define MASS_MAP_SVH
// =====================================================================
// Function-select codes
`define MASS_FN_CLEAR      8'h00
`define MASS_FN_CONTINUE   8'h01
`define MASS_FN_ABORT      8'h02
`define MASS_FN_FULL_ALL   8'h0a
`define MASS_FN_FULL_LO    8'h0b
`define MASS_FN_FULL_HI    8'h0e
`define MASS_FN_CHECK_ALL  8'h14
`define MASS_FN_CHECK_LO   8'h15
`define MASS_FN_CHECK_HI   8'h18
`define MASS_FN_IDENT_ALL  8'h1e
`define MASS_FN_IDENT_LO   8'h1f
`define MASS_FN_IDENT_HI   8'h22
// =====================================================================
// Status codes
`define MASS_ST_IDLE       4'h0
`define MASS_ST_OK         4'h1
`define MASS_ST_PHASE_ONE  4'h2
`define MASS_ST_PHASE_TWO  4'h3
`define MASS_ST_NO_RELEASE 4'h4
`define MASS_ST_IDENT      4'h5
`define MASS_ST_BUSY_LOCAL 4'h6
`define MASS_ST_ERROR      4'h7
`define MASS_ST_ASYM_WARN  4'h8
`define MASS_ST_CFG_UNSUP  4'h9
`define MASS_ST_REJECTED   4'ha
// =====================================================================
// Set-selection masks and reset timing
`define MASS_SET_ALL       4'hf
`define MASS_RST_PULSE_NS  400
`define MASS_CLK_NS        100
`define MASS_RST_CYCLES    ((`MASS_RST_PULSE_NS + `MASS_CLK_NS - 1) / `MASS_CLK_NS)
`endif

/* File: hdl/mass_pkg.sv */
// Types for the auto set-up sequencer.
// Assumes nothing beyond the constants header.
package mass_pkg;
  typedef enum logic [1:0] {
    MASS_OP_FULL,
    MASS_OP_CHECK,
    MASS_OP_IDENT
  } mass_op_type;

  typedef enum logic [3:0] {
    MASS_S_IDLE,
    MASS_S_CHECK,
    MASS_S_CALC,
    MASS_S_WAIT_REL,
    MASS_S_IDENT,
    MASS_S_WARN,
    MASS_S_STORE,
    MASS_S_DONE,
    MASS_S_FAIL,
    MASS_S_ABORT
  } mass_state_type;
endpackage

/* File: hdl/mass_step_engine.sv */
// Step engine: hands each sequencer step to the external compute units
// and returns their completion. Assumes unit done/fail are pulses.
module mass_step_engine (
  input  wire logic   core_clk,
  input  wire logic   sys_rst,
  mass_task_if.eng    tsk,
  output logic [1:0]  unitStep,
  output logic        unitGo,
  input  wire logic   unitDone,
  input  wire logic   unitFail,
  input  wire logic   unitAsym
);
  logic busy_r;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
    end else if (tsk.start) begin
      busy_r <= 1'b1;
    end else if (unitDone || unitFail) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      unitStep <= 2'h0;
      unitGo   <= 1'b0;
    end else begin
      unitGo <= tsk.start;
      if (tsk.start) begin
        unitStep <= tsk.step;
      end
    end
  end

  assign tsk.done = busy_r && unitDone && !unitFail;
  assign tsk.fail = busy_r && unitFail;
  assign tsk.asym = busy_r && unitDone && unitAsym;
endmodule

/* File: hdl/mass_task_if.sv */
// Handshake between sequencer and its step engine.
// Assumes one clock domain.
interface mass_task_if;
  logic       start;
  logic [1:0] step;
  logic       done;
  logic       fail;
  logic       asym;
  modport seq (output start, output step, input done, input fail, input asym);
  modport eng (input start, input step, output done, output fail, output asym);
endinterface

/* File: hdl/motor_auto_setup_sequencer.sv */
// Auto set-up sequencer started by a host-written function-select code.
// Assumes host write strobe, release input and unit handshakes are synchronous.
// =====================================================================
// How it works
// RULE1 - Code 0 does nothing but clear the status.
// RULE2 - Code 1 acknowledges the warning and resumes the paused sequence.
// RULE3 - Code 2 stops the sequence and pulses a whole-inverter reset.
// RULE4 - Code 10 runs full set-up, stores into all four sets.
// RULE5 - Codes 11..14 run full set-up, store into set code minus ten.
// RULE6 - Code 20 checks rated motor data across all four sets.
// RULE7 - Codes 21..24 check rated data in set code minus twenty.
// RULE8 - Code 30 identifies, calculates, stores into all four sets.
// RULE9 - Codes 31..34 identify, calculate, store into set code minus thirty.
// RULE10 - A function starts at once on write when release is asserted.
// RULE11 - Status output is updated every cycle while running.
// RULE12 - Status reports ok when the sequence finishes without error.
// RULE13 - Status shows phase one while checking, phase two while calculating.
// RULE14 - Identification without release reports missing release and waits.
// RULE15 - Status shows identification while identification runs.
// RULE16 - A local keypad set-up blocks host starts; status shows already active.
// RULE17 - Any step failure puts status into the error state.
// RULE18 - Phase asymmetry reports a warning; continue code acknowledges it.
// RULE19 - Dropping release disables the power stage and halts identification.
// RULE20 - Unsupported drive configuration raises its own error status.
// RULE21 - Each status is a distinct small code; unknown codes are rejected.
`include "mass_map.svh"
module motor_auto_setup_sequencer
  import mass_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        fnWrite,
  input  wire logic [7:0]  fnCode,
  input  wire logic        controllerReleaseInput,
  input  wire logic        localSetupActive,
  input  wire logic        configSupported,
  output logic [1:0]       unitStep,
  output logic             unitGo,
  input  wire logic        unitDone,
  input  wire logic        unitFail,
  input  wire logic        unitAsym,
  output logic [3:0]       setupStatus,
  output logic [3:0]       storeSets,
  output logic             storeStrobe,
  output logic             powerStageEnable,
  output logic             inverterReset
);
  // ===================================================================
  // Decode and step engine
  mass_op_type    fnOp;
  logic [3:0]     fnSets;
  logic           fnRun;
  logic           fnValid;
  mass_task_if    tsk();

  mass_code_decode u_dec (
    .fnCode  (fnCode),
    .fnOp    (fnOp),
    .fnSets  (fnSets),
    .fnRun   (fnRun),
    .fnValid (fnValid)
  );

  mass_step_engine u_eng (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tsk      (tsk),
    .unitStep (unitStep),
    .unitGo   (unitGo),
    .unitDone (unitDone),
    .unitFail (unitFail),
    .unitAsym (unitAsym)
  );

  // ===================================================================
  // Sequencer state
  mass_state_type state_r;
  mass_state_type state_nxt;
  mass_op_type    op_r;
  logic [3:0]     sets_r;
  logic [3:0]     status_r;
  logic [3:0]     status_nxt;
  logic [2:0]     rstCnt_r;
  logic           startGo;
  logic           inIdent;

  // Host starts are accepted only from idle or a finished state.
  logic seqIdle;
  assign seqIdle = (state_r == MASS_S_IDLE) || (state_r == MASS_S_DONE) ||
                   (state_r == MASS_S_FAIL);
  assign startGo = fnWrite && fnRun && seqIdle && !localSetupActive &&
                   configSupported && controllerReleaseInput; // [RULE10] [RULE16] [RULE20]
  assign inIdent = (state_r == MASS_S_IDENT);

  always_comb begin
    state_nxt  = state_r;
    status_nxt = status_r;
    tsk.start  = 1'b0;
    tsk.step   = 2'h0;
    case (state_r)
      MASS_S_IDLE, MASS_S_DONE, MASS_S_FAIL: begin
        if (fnWrite && fnCode == `MASS_FN_CLEAR) begin
          state_nxt  = MASS_S_IDLE;
          status_nxt = `MASS_ST_IDLE; // [RULE1]
        end else if (fnWrite && fnRun && localSetupActive) begin
          status_nxt = `MASS_ST_BUSY_LOCAL; // [RULE16]
        end else if (fnWrite && fnRun && !configSupported) begin
          state_nxt  = MASS_S_FAIL;
          status_nxt = `MASS_ST_CFG_UNSUP; // [RULE20]
        end else if (fnWrite && fnRun && !controllerReleaseInput) begin
          status_nxt = `MASS_ST_NO_RELEASE; // [RULE10]
        end else if (startGo) begin
          if (fnOp == MASS_OP_IDENT) begin
            state_nxt = MASS_S_CALC;
            status_nxt = `MASS_ST_PHASE_TWO; // [RULE13]
            tsk.start = 1'b1;
            tsk.step  = 2'h1;
          end else begin
            state_nxt  = MASS_S_CHECK;
            status_nxt = `MASS_ST_PHASE_ONE; // [RULE13]
            tsk.start  = 1'b1;
            tsk.step   = 2'h0;
          end
        end else if (fnWrite && !fnValid) begin
          status_nxt = `MASS_ST_REJECTED; // [RULE21]
        end
      end

      MASS_S_CHECK: begin
        if (tsk.fail) begin
          state_nxt  = MASS_S_FAIL;
          status_nxt = `MASS_ST_ERROR; // [RULE17]
        end else if (tsk.done) begin
          if (op_r == MASS_OP_CHECK) begin
            state_nxt  = MASS_S_DONE;
            status_nxt = `MASS_ST_OK; // [RULE12]
          end else begin
            state_nxt  = MASS_S_CALC;
            status_nxt = `MASS_ST_PHASE_TWO; // [RULE13]
            tsk.start  = 1'b1;
            tsk.step   = 2'h1;
          end
        end
      end

      MASS_S_CALC: begin
        if (tsk.fail) begin
          state_nxt  = MASS_S_FAIL;
          status_nxt = `MASS_ST_ERROR; // [RULE17]
        end else if (tsk.done) begin
          state_nxt  = MASS_S_WAIT_REL;
          status_nxt = `MASS_ST_NO_RELEASE;
        end
      end

      // Passes through one cycle of missing-release status even when release is present.
      MASS_S_WAIT_REL: begin
        if (controllerReleaseInput) begin
          state_nxt  = MASS_S_IDENT;
          status_nxt = `MASS_ST_IDENT; // [RULE15]
          tsk.start  = 1'b1;
          tsk.step   = 2'h2;
        end else begin
          status_nxt = `MASS_ST_NO_RELEASE; // [RULE14]
        end
      end

      MASS_S_IDENT: begin
        if (!controllerReleaseInput) begin
          state_nxt  = MASS_S_FAIL;
          status_nxt = `MASS_ST_ERROR; // [RULE19]
        end else if (tsk.fail) begin
          state_nxt  = MASS_S_FAIL;
          status_nxt = `MASS_ST_ERROR; // [RULE17]
        end else if (tsk.asym) begin
          state_nxt  = MASS_S_WARN;
          status_nxt = `MASS_ST_ASYM_WARN; // [RULE18]
        end else if (tsk.done) begin
          state_nxt = MASS_S_STORE;
        end
      end

      MASS_S_WARN: begin
        if (fnWrite && fnCode == `MASS_FN_CONTINUE) begin
          state_nxt  = MASS_S_STORE; // [RULE2] [RULE18]
          status_nxt = `MASS_ST_IDENT;
        end
      end

      MASS_S_STORE: begin
        state_nxt  = MASS_S_DONE;
        status_nxt = `MASS_ST_OK; // [RULE12]
      end

      MASS_S_ABORT: begin
        if (rstCnt_r == 3'h0) begin
          state_nxt  = MASS_S_IDLE;
          status_nxt = `MASS_ST_IDLE;
        end
      end

      default: begin
        state_nxt = MASS_S_IDLE;
      end
    endcase

    // Abort overrides every state except abort itself, including a running step.
    if (fnWrite && fnCode == `MASS_FN_ABORT && state_r != MASS_S_ABORT) begin
      state_nxt  = MASS_S_ABORT; // [RULE3]
      status_nxt = `MASS_ST_IDLE;
      tsk.start  = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r  <= MASS_S_IDLE;
      status_r <= `MASS_ST_IDLE;
    end else begin
      state_r  <= state_nxt;
      status_r <= status_nxt; // [RULE11]
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_r   <= MASS_OP_FULL;
      sets_r <= 4'h0;
    end else if (startGo) begin
      op_r   <= fnOp;
      sets_r <= fnSets; // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9]
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstCnt_r <= 3'h0;
    end else if (state_nxt == MASS_S_ABORT && state_r != MASS_S_ABORT) begin
      rstCnt_r <= 3'(`MASS_RST_CYCLES - 1);
    end else if (rstCnt_r != 3'h0) begin
      rstCnt_r <= rstCnt_r - 3'h1;
    end
  end

  // ===================================================================
  // Outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      storeStrobe      <= 1'b0;
      storeSets        <= 4'h0;
      powerStageEnable <= 1'b0;
      inverterReset    <= 1'b0;
    end else begin
      storeStrobe      <= (state_r == MASS_S_STORE);
      storeSets        <= (state_r == MASS_S_STORE) ? sets_r : 4'h0;
      // Power stage only runs during identification with release present.
      powerStageEnable <= (state_nxt == MASS_S_IDENT) && controllerReleaseInput; // [RULE19]
      inverterReset    <= (state_nxt == MASS_S_ABORT); // [RULE3]
    end
  end

  assign setupStatus = status_r;

  // ===================================================================
  // Assertions
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE1]
    (fnWrite && fnCode == `MASS_FN_CLEAR && seqIdle) |=> setupStatus == `MASS_ST_IDLE)
    else $error("clear code did not clear status");

  AST_ABORT_RST: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE3]
    (fnWrite && fnCode == `MASS_FN_ABORT && state_r != MASS_S_ABORT) |=> inverterReset)
    else $error("abort did not reset inverter");

  AST_START: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE10]
    (startGo && fnCode != `MASS_FN_ABORT) |=> unitGo)
    else $error("start did not launch a step");

  AST_NOREL_START: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE10]
    (fnWrite && fnRun && seqIdle && !controllerReleaseInput && !localSetupActive &&
     configSupported) |=> !unitGo)
    else $error("start without release");

  AST_LOCAL: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE16]
    (fnWrite && fnRun && seqIdle && localSetupActive) |=>
      (setupStatus == `MASS_ST_BUSY_LOCAL && !unitGo))
    else $error("host start ran during local set-up");

  AST_WAITREL: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE14]
    (state_r == MASS_S_WAIT_REL && !controllerReleaseInput && !fnWrite) |=>
      setupStatus == `MASS_ST_NO_RELEASE)
    else $error("missing release not reported");

  AST_POWER: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE19]
    powerStageEnable |-> $past(controllerReleaseInput))
    else $error("power stage on without release");

  AST_FAIL: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE17]
    (state_r == MASS_S_CHECK && tsk.fail && !fnWrite) |=> setupStatus == `MASS_ST_ERROR)
    else $error("failure not reported");

  AST_CONT: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE2]
    (state_r == MASS_S_WARN && fnWrite && fnCode == `MASS_FN_CONTINUE) |=> ##1 storeStrobe)
    else $error("continue did not resume");

  AST_CFG: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE20]
    (fnWrite && fnRun && seqIdle && !localSetupActive && !configSupported) |=>
      setupStatus == `MASS_ST_CFG_UNSUP)
    else $error("unsupported config not flagged");

  // Status follows the state: check, calculation and identification each show their own phase code.
  AST_CHECK_ST: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE13]
    (state_r == MASS_S_CHECK) |-> setupStatus == `MASS_ST_PHASE_ONE)
    else $error("check phase not reported");

  AST_CALC_ST: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE13]
    (state_r == MASS_S_CALC) |-> setupStatus == `MASS_ST_PHASE_TWO)
    else $error("calculation phase not reported");

  AST_IDENT_ST: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE15]
    inIdent |-> setupStatus == `MASS_ST_IDENT)
    else $error("identification not reported");

  // An abort in the store cycle overwrites the ok status, so it is left out.
  AST_STORE_OK: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE12]
    (state_r == MASS_S_STORE && !fnWrite) |=>
      (storeStrobe && setupStatus == `MASS_ST_OK))
    else $error("store without ok status");

  AST_REJECT: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE21]
    (fnWrite && !fnValid && seqIdle) |=> (setupStatus == `MASS_ST_REJECTED && !unitGo))
    else $error("unknown code not rejected");

  COV_FULL: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_r == MASS_S_STORE && op_r == MASS_OP_FULL);

  COV_CHECK: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_r == MASS_S_CHECK && op_r == MASS_OP_CHECK ##1 state_r == MASS_S_DONE);

  COV_WARN: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_r == MASS_S_WARN ##1 state_r == MASS_S_STORE);

  COV_ABORT: cover property (@(posedge core_clk) disable iff (sys_rst) inverterReset);
endmodule

/* File: test/mass_unit_model.sv */
// Behavioural compute unit answering the sequencer's step requests.
// Assumes one clock; answers are driven 1 ns after the rising edge.
// =====================================================================
// Step unit
module mass_unit_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       unitGo,
  input  wire logic [1:0] unitStep,
  input  wire logic [7:0] delayCyc,
  input  wire logic       failNext,
  input  wire logic       asymNext,
  output logic            unitDone,
  output logic            unitFail,
  output logic            unitAsym
);
  timeunit 1ns;
  timeprecision 100ps;
  int         cnt;
  logic       pend;
  logic [1:0] stp;
  initial begin
    unitDone = 1'b0;
    unitFail = 1'b0;
    unitAsym = 1'b0;
    pend = 1'b0;
    cnt = 0;
    stp = 2'h0;
    forever begin
      @(posedge core_clk);
      #1;
      unitDone = 1'b0;
      unitFail = 1'b0;
      unitAsym = 1'b0;
      if (sys_rst) begin
        pend = 1'b0;
      end else if (pend && cnt <= 1) begin
        pend = 1'b0;
        if (failNext) begin
          unitFail = 1'b1;
        end else begin
          unitDone = 1'b1;
          unitAsym = asymNext && stp == 2'h2;
        end
      end else if (pend) begin
        cnt--;
      end
      // A new request replaces any answer still owed after an abort
      if (unitGo === 1'b1) begin
        pend = 1'b1;
        cnt = delayCyc;
        stp = unitStep;
      end
    end
  end
endmodule

/* File: test/motor_auto_setup_sequencer_tb.sv */
// Self-checking bench for the auto set-up sequencer.
// Assumes the step unit model and the constants header.
`include "mass_map.svh"
module motor_auto_setup_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk, sys_rst, fnWrite, controllerReleaseInput, localSetupActive;
  logic       configSupported, failNext, asymNext, unitGo, unitDone, unitFail, unitAsym;
  logic       storeStrobe, powerStageEnable, inverterReset, rec;
  logic [7:0] fnCode, unitDelay, badCode;
  logic [1:0] unitStep;
  logic [3:0] setupStatus, storeSets, lastSets;
  logic [3:0] seen[$];
  logic [1:0] steps[$];
  int         n_errors, n_checks, nStore, nRst, nGo, cyc, seed, g;
  logic [3:0] refExp[3] = '{`MASS_ST_BUSY_LOCAL, `MASS_ST_CFG_UNSUP, `MASS_ST_NO_RELEASE};
  motor_auto_setup_sequencer i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .fnWrite(fnWrite), .fnCode(fnCode), .controllerReleaseInput(controllerReleaseInput),
    .localSetupActive(localSetupActive), .configSupported(configSupported),
    .unitStep(unitStep), .unitGo(unitGo), .unitDone(unitDone), .unitFail(unitFail),
    .unitAsym(unitAsym), .setupStatus(setupStatus), .storeSets(storeSets),
    .storeStrobe(storeStrobe), .powerStageEnable(powerStageEnable),
    .inverterReset(inverterReset));
  mass_unit_model i_unit (.core_clk(core_clk), .sys_rst(sys_rst), .unitGo(unitGo),
    .unitStep(unitStep), .delayCyc(unitDelay), .failNext(failNext), .asymNext(asymNext),
    .unitDone(unitDone), .unitFail(unitFail), .unitAsym(unitAsym));
  // =====================================================================
  // Clock, timeout and monitors
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  // Sampled mid-cycle so every registered output has settled
  always @(negedge core_clk) begin
    if (rec && (seen.size() == 0 || seen[$] !== setupStatus)) seen.push_back(setupStatus);
    if (unitGo === 1'b1) begin
      nGo++;
      if (rec) steps.push_back(unitStep);
    end
    if (storeStrobe === 1'b1) begin
      nStore++;
      lastSets = storeSets;
      chkSt("status at store", `MASS_ST_OK, setupStatus);
    end
    if (inverterReset === 1'b1) nRst++;
  end
  // =====================================================================
  // Compare and drive tasks
  task automatic chkSt(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkSets(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkNum(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      n_errors++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] code);
    fnWrite = 1'b1;
    fnCode = code;
    tick(1);
    fnWrite = 1'b0;
    fnCode = 8'($random(seed));
  endtask
  task automatic waitSt(input logic [3:0] st);
    for (int i = 0; i < 300 && setupStatus !== st; i++) tick(1);
    chkSt("awaited status", st, setupStatus);
  endtask
  function automatic bit isValid(input logic [7:0] c);
    return c <= 8'h02 || (c >= 8'h0a && c <= 8'h22 && c % 10 <= 4);
  endfunction
  task stop_test;
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reference model: expected status trail, step order and store mask per code
  task automatic runOk(input logic [7:0] code);
    int         grp, sub;
    logic [3:0] exp[$];
    logic [1:0] expStep[$];
    grp = code / 10;
    sub = code % 10;
    if (grp == 1) begin
      exp = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h1};
      expStep = '{2'h0, 2'h1, 2'h2};
    end else if (grp == 2) begin
      exp = '{4'h2, 4'h1};
      expStep = '{2'h0};
    end else begin
      exp = '{4'h3, 4'h4, 4'h5, 4'h1};
      expStep = '{2'h1, 2'h2};
    end
    unitDelay = 8'(1 + $unsigned($random(seed)) % 6);
    seen.delete();
    steps.delete();
    nStore = 0;
    wr(code);
    rec = 1'b1;
    chkSt("first status", exp[0], setupStatus);
    waitSt(`MASS_ST_OK);
    tick(2);
    rec = 1'b0;
    chkNum("status trail length", exp.size(), seen.size());
    for (int i = 0; i < exp.size() && i < seen.size(); i++)
      chkSt("status trail", exp[i], seen[i]);
    chkNum("step count", expStep.size(), steps.size());
    for (int i = 0; i < expStep.size() && i < steps.size(); i++)
      chkSt("step", {2'h0, expStep[i]}, {2'h0, steps[i]});
    chkNum("store pulses", grp == 2 ? 0 : 1, nStore);
    if (grp != 2)
      chkSets("store sets", sub == 0 ? `MASS_SET_ALL : 4'(1 << (sub - 1)), lastSets);
  endtask
  // =====================================================================
  // Main sequence
  initial begin
    seed = 13020;
    {fnWrite, localSetupActive, failNext, asymNext, rec} = '0;
    controllerReleaseInput = 1'b1;
    configSupported = 1'b1;
    fnCode = 8'h00;
    unitDelay = 8'h02;
    sys_rst = 1'b1;
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    chkSt("reset status", `MASS_ST_IDLE, setupStatus);
    for (int c = 10; c <= 34; c++)
      if (c % 10 <= 4) runOk(8'(c));
    wr(8'h00);
    chkSt("cleared", `MASS_ST_IDLE, setupStatus);
    g = nGo;
    repeat (6) begin
      tick(1);
      do badCode = 8'($random(seed)); while (isValid(badCode));
      wr(badCode);
      chkSt("unknown code", `MASS_ST_REJECTED, setupStatus);
      wr(8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      tick(1);
      localSetupActive = (i == 0);
      configSupported = (i != 1);
      controllerReleaseInput = (i != 2);
      wr(8'h0b);
      chkSt("refused start", refExp[i], setupStatus);
      tick(4);
      {localSetupActive, configSupported, controllerReleaseInput} = 3'b011;
      wr(8'h00);
    end
    chkNum("starts while refused", g, nGo);
    tick(1);
    // Release missing when identification is reached
    unitDelay = 8'h14;
    wr(8'h1f);
    waitSt(`MASS_ST_PHASE_TWO);
    controllerReleaseInput = 1'b0;
    waitSt(`MASS_ST_NO_RELEASE);
    g = nGo;
    tick(10);
    chkSt("held waiting", `MASS_ST_NO_RELEASE, setupStatus);
    chkNum("no start without release", g, nGo);
    controllerReleaseInput = 1'b1;
    waitSt(`MASS_ST_IDENT);
    waitSt(`MASS_ST_OK);
    // Release dropped during identification
    wr(8'h20);
    waitSt(`MASS_ST_IDENT);
    chkSt("power stage on", 4'h1, {3'h0, powerStageEnable});
    controllerReleaseInput = 1'b0;
    tick(3);
    chkSt("release dropped", `MASS_ST_ERROR, setupStatus);
    chkSt("power stage", 4'h0, {3'h0, powerStageEnable});
    controllerReleaseInput = 1'b1;
    wr(8'h00);
    tick(1);
    failNext = 1'b1;
    unitDelay = 8'h03;
    wr(8'h0b);
    waitSt(`MASS_ST_ERROR);
    failNext = 1'b0;
    // Asymmetry warning then continue
    asymNext = 1'b1;
    wr(8'h21);
    waitSt(`MASS_ST_ASYM_WARN);
    asymNext = 1'b0;
    nStore = 0;
    wr(8'h01);
    waitSt(`MASS_ST_OK);
    tick(2);
    chkNum("store after continue", 1, nStore);
    chkSets("continue sets", 4'h4, lastSets);
    // Abort in mid-run
    unitDelay = 8'h14;
    wr(8'h0a);
    tick(3);
    nRst = 0;
    wr(8'h02);
    tick(20);
    chkNum("inverter reset cycles", `MASS_RST_CYCLES, nRst);
    chkSt("status after abort", `MASS_ST_IDLE, setupStatus);
    stop_test();
  end
endmodule
